// ===== bench/apso_capture_model.sv
// capture model: latches each sample word on the forwarded clock rise
// assumes all device outputs are registered on ref_clk
`timescale 1ns/1ps
`default_nettype none
module apso_capture_model
    import apso_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [CODE_W-1:0] bitsT,
    input wire logic [CODE_W-1:0] bitsC,
    input wire logic fwdT,
    input wire logic fwdC,
    input wire logic ovrT,
    input wire logic ovrC,
    output logic capStb,
    output logic [WORD_W-1:0] capWord,
    output logic pairOk,
    output int capCount
);
    logic fwdQ = 1'b0;
    logic stbQ = 1'b0;
    int cntQ = 0;
    assign capStb = stbQ;
    assign capCount = cntQ;
    // data and flag are taken together at the forwarded clock rise
    always @(posedge ref_clk)
    begin
        fwdQ <= fwdT;
        stbQ <= fwdT && !fwdQ;
        if (fwdT && !fwdQ)
        begin
            capWord <= {ovrT, bitsT};
            pairOk <= (bitsC === ~bitsT) && (ovrC === ~ovrT) && (fwdC === ~fwdT);
            cntQ <= cntQ + 1;
        end
    end
endmodule
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for the parallel sample output block
// assumes the rtl package and the capture model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
    import apso_pkg::*;
    logic ref_clk = 0, rst = 1, sT = 0, sC = 1, calN = 1, halveN = 1, twosN = 1, refSel = 0;
    logic [7:0] coreCode = 0, wrData = 0, rdData, bT, bC;
    logic coreOver = 0, regWr = 0, regRd = 0, irq, fT, fC, oT, oC, refExt;
    logic [3:0] addr = 0;
    logic capStb, pairOk, cmpOn = 0, overSeen = 0;
    logic [8:0] capWord;
    logic [8:0] sent [0:4095];
    logic [2:0] ph = 0;
    int capCount, riseCnt = 0, fallCnt = 0, firstIdx = 0, skip = 0, idx, cyc = 0, badCount = 0, checksDone = 0;

    apso_top #(.CAL_CYCLES(20)) dut (.ref_clk(ref_clk), .rst(rst), .sample_clock_in_true(sT),
        .sample_clock_in_comp(sC), .cal_reset_n(calN), .clock_halve_sel_n(halveN),
        .twos_format_sel_n(twosN), .ref_source_sel(refSel), .coreCode(coreCode), .coreOver(coreOver),
        .regAddr(addr), .regWrData(wrData), .regWr(regWr), .regRd(regRd), .regRdData(rdData),
        .irq(irq), .sample_bits_true(bT), .sample_bits_comp(bC), .fwd_clock_true(fT),
        .fwd_clock_comp(fC), .overrange_flag_true(oT), .overrange_flag_comp(oC),
        .ref_source_ext(refExt));
    apso_capture_model cap (.ref_clk(ref_clk), .bitsT(bT), .bitsC(bC), .fwdT(fT), .fwdC(fC),
        .ovrT(oT), .ovrC(oC), .capStb(capStb), .capWord(capWord), .pairOk(pairOk), .capCount(capCount));

    // 25 ns system clock
    initial forever #12.5 ref_clk = ~ref_clk;

    task automatic summarize();
        if (badCount == 0 && checksDone > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic tally(input logic ok, input logic [8:0] got, input logic [8:0] exp);
        checksDone++;
        if (!ok)
        begin
            badCount++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic checkBit(input logic got, input logic exp);
        tally(got === exp, 9'(got), 9'(exp));
    endtask
    task automatic checkReg(input logic [7:0] got, input logic [7:0] exp);
        tally(got === exp, 9'(got), 9'(exp));
    endtask
    task automatic checkWord(input logic [8:0] got, input logic [8:0] exp);
        tally(got === exp, got, exp);
    endtask

    // expected pin word: low format select turns the msb round
    function automatic logic [8:0] conv(input logic [8:0] w, input logic fmtN);
        return {w[8], w[7] ^ ~fmtN, w[6:0]};
    endfunction

    // one-cycle write, strobe dropped on the next edge
    task automatic regWrite(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        regWr <= 1;
        addr <= a;
        wrData <= v;
        @(posedge ref_clk);
        regWr <= 0;
    endtask
    // one-cycle read, data taken in the following cycle
    task automatic regRead(input logic [3:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        regRd <= 1;
        addr <= a;
        @(posedge ref_clk);
        regRd <= 0;
        #1 v = rdData;
    endtask
    task automatic waitCyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic waitRun();
        logic [7:0] d;
        for (int n = 0; n < 200; n++)
        begin
            regRead(REG_STATE, d);
            if (d[0] === 1'b1)
                break;
        end
        checkBit(d[0], 1'b1);
    endtask

    // sample clock of eight ref_clk cycles; core word changes mid-period
    always @(posedge ref_clk)
    begin
        ph <= ph + 3'd1;
        if (ph == 3'd0)
        begin
            sT <= 1;
            sC <= 0;
            sent[riseCnt] = {coreOver, coreCode};
            riseCnt++;
        end
        if (ph == 3'd4)
        begin
            sT <= 0;
            sC <= 1;
            fallCnt++;
            coreCode <= 8'($urandom);
            coreOver <= ($urandom_range(7) == 0);
        end
    end

    // each capture must carry the word taken 28 events earlier
    always @(posedge ref_clk)
    begin
        if (capStb === 1'b1 && cmpOn)
        begin
            idx = fallCnt - 1 - 28;
            if (skip > 0)
                skip--;
            else if (idx >= firstIdx)
            begin
                checkWord(capWord, conv(sent[idx], twosN));
                if (sent[idx][8])
                    overSeen = 1'b1;
                checkBit(pairOk, 1'b1);
            end
        end
    end

    // hang guard
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            badCount++;
            summarize();
        end
    end

    // main sequence
    initial
    begin
        logic [7:0] d;
        int c0;
        void'($urandom(32'h458a_661b));
        repeat (4) @(posedge ref_clk);
        rst <= 0;
        waitCyc(5);
        checkBit(oT, 1'b1);
        waitRun();
        waitCyc(2);
        checkBit(irq, 1'b0);
        checkReg(rdData, 8'h00);
        regRead(REG_MASK, d);
        checkReg(d, 8'h00);
        regWrite(REG_MASK, 8'h01);
        waitCyc(2);
        checkBit(irq, 1'b1);
        regWrite(REG_MASK, 8'h00);
        waitCyc(2);
        checkBit(irq, 1'b0);
        regWrite(REG_MASK, 8'h01);
        regRead(REG_MASK, d);
        checkReg(d, 8'h01);
        regRead(REG_STATUS, d);
        checkBit(d[0], 1'b1);
        waitCyc(2);
        checkBit(irq, 1'b0);
        regRead(4'hC, d);
        checkReg(d, 8'h00);
        regWrite(REG_STATE, 8'h00);
        regRead(REG_STATE, d);
        checkBit(d[0], 1'b1);
        // streaming in both output formats
        firstIdx = riseCnt;
        cmpOn = 1;
        waitCyc(400);
        @(posedge ref_clk) twosN <= 0;
        skip = 32;
        waitCyc(480);
        cmpOn = 0;
        // an over-range word shown in run leaves its status bit set
        regRead(REG_STATUS, d);
        checkBit(d[1], overSeen);
        for (int r = 0; r < 2; r++)
        begin
            @(posedge ref_clk) refSel <= r[0];
            waitCyc(5);
            checkBit(refExt, r[0]);
            regRead(REG_STATE, d);
            checkBit(d[5], r[0]);
            checkBit(d[4], 1'b0);
            checkBit(d[3], 1'b1);
        end
        // recalibration request held low well past one cycle
        @(posedge ref_clk) calN <= 0;
        waitCyc(4);
        for (int n = 0; n < 8; n++)
        begin
            waitCyc(1);
            checkBit(fT, 1'b0);
            checkBit(oT, 1'b1);
        end
        regRead(REG_STATE, d);
        checkBit(d[2], 1'b1);
        @(posedge ref_clk) calN <= 1;
        waitCyc(6);
        checkBit(oT, 1'b1);
        waitRun();
        waitCyc(2);
        checkBit(irq, 1'b1);
        regRead(REG_STATUS, d);
        checkBit(d[0], 1'b1);
        waitCyc(2);
        checkBit(irq, 1'b0);
        // forwarded clock rate with and without halving
        for (int n = 1; n >= 0; n--)
        begin
            @(posedge ref_clk) halveN <= n[0];
            waitCyc(64);
            c0 = capCount;
            waitCyc(128);
            checkReg(8'(capCount - c0), n ? 8'd16 : 8'd8);
        end
        summarize();
    end
endmodule
`default_nettype wire

// ===== rtl/apso_delay_line.sv
// fixed-depth shift line that delays sample words by a number of sample events
// assumes advance is a one-cycle pulse on ref_clk
`timescale 1ns/1ps
`default_nettype none
module apso_delay_line
    import apso_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic advance,
    input wire logic [WORD_W-1:0] din,
    output logic [WORD_W-1:0] dout
);

    typedef struct packed {
        logic [PIPE_LAT-1:0][WORD_W-1:0] mem;
    } apso_line_t;

    apso_line_t st_ff;
    apso_line_t nxt_st;

    // shift one place per sample event
    always_comb
    begin
        nxt_st = st_ff;
        if (advance)
        begin
            nxt_st.mem = {st_ff.mem[PIPE_LAT-2:0], din};
        end
    end

    // register the line
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign dout = st_ff.mem[PIPE_LAT-1];

    // word enters at the head on each event
    line_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
        advance |=> st_ff.mem[0] == $past(din))
        else $error("delay line head not loaded");

    // line holds still between events
    line_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        !advance |=> $stable(st_ff.mem))
        else $error("delay line moved without event");

endmodule
`default_nettype wire

// ===== rtl/apso_pkg.sv
// constants shared by the parallel sample output block
// assumes a single 40 MHz ref_clk domain and synchronous reset
package apso_pkg;

    // clock and timing
    localparam longint CLK_HZ = 64'd40_000_000;
    localparam longint CAL_TIME_MS = 64'd190;
    localparam longint CAL_CYCLES_DEF = (CAL_TIME_MS * CLK_HZ) / 64'd1000;
    localparam int CAL_CNT_W = 23;

    // pipeline latency in sample clocks
    localparam int PIPE_LAT = 28;
    localparam int CODE_W = 8;
    localparam int WORD_W = 9;
    localparam int OVR_BIT = 8;
    localparam int MSB_BIT = 7;

    // synchroniser bit positions
    localparam int SYNC_W = 6;
    localparam int SY_CLKT = 0;
    localparam int SY_CLKC = 1;
    localparam int SY_RSTN = 2;
    localparam int SY_HALVE = 3;
    localparam int SY_TWOS = 4;
    localparam int SY_REF = 5;

    // register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_MASK = 4'h4;
    localparam logic [3:0] REG_STATE = 4'h8;

    // status and mask bits
    localparam int EVT_W = 2;
    localparam int EV_CALDONE = 0;
    localparam int EV_OVR = 1;
    localparam logic [1:0] MASK_RST = 2'h0;

    // state register bits
    localparam int ST_RUN = 0;
    localparam int ST_CAL = 1;
    localparam int ST_HOLD = 2;
    localparam int ST_HALVE = 3;
    localparam int ST_TWOS = 4;
    localparam int ST_REF = 5;

    typedef enum logic [1:0] {APSO_HOLD, APSO_CAL, APSO_RUN} apso_mode_t;

endpackage

// ===== rtl/apso_top.sv
// digital output side of a pipelined 8-bit sampling converter
// assumes converter core results arrive on ref_clk; pins pass two flip-flops
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module apso_top
    import apso_pkg::*;
#(
    parameter int CAL_CYCLES = int'(CAL_CYCLES_DEF)
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sample_clock_in_true,
    input wire logic sample_clock_in_comp,
    input wire logic cal_reset_n,
    input wire logic clock_halve_sel_n,
    input wire logic twos_format_sel_n,
    input wire logic ref_source_sel,
    input wire logic [CODE_W-1:0] coreCode,
    input wire logic coreOver,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdData,
    output logic irq,
    output logic [CODE_W-1:0] sample_bits_true,
    output logic [CODE_W-1:0] sample_bits_comp,
    output logic fwd_clock_true,
    output logic fwd_clock_comp,
    output logic overrange_flag_true,
    output logic overrange_flag_comp,
    output logic ref_source_ext
);

    typedef struct packed {
        logic [SYNC_W-1:0] syncA;
        logic [SYNC_W-1:0] syncB;
        logic clkPrev;
        logic divPhase;
        apso_mode_t mode;
        logic [CAL_CNT_W-1:0] calCnt;
        logic [CODE_W-1:0] dataTrue;
        logic [CODE_W-1:0] dataComp;
        logic fwdTrue;
        logic fwdComp;
        logic overTrue;
        logic overComp;
        logic refExt;
        logic [EVT_W-1:0] status;
        logic [EVT_W-1:0] mask;
        logic irq;
        logic [DATA_W-1:0] rdData;
    } apso_state_t;

    localparam logic [CAL_CNT_W-1:0] CAL_LOAD = CAL_CNT_W'(CAL_CYCLES - 1);

    // power-on starts a calibration with outputs quiet and over-range high
    localparam apso_state_t ST_RESET = '{
        syncA: '0, syncB: '0, clkPrev: 1'b0, divPhase: 1'b0,
        mode: APSO_CAL, calCnt: CAL_LOAD,
        dataTrue: '0, dataComp: '1, fwdTrue: 1'b0, fwdComp: 1'b1,
        overTrue: 1'b1, overComp: 1'b0, refExt: 1'b0,
        status: '0, mask: MASK_RST, irq: 1'b0, rdData: '0};

    apso_state_t st_ff;
    apso_state_t nxt_st;

    logic clkLvl;
    logic clkRise;
    logic clkFall;
    logic sampleEvt;
    logic fwdRiseEvt;
    logic [WORD_W-1:0] pipeOut;

    // output code for the chosen number format
    function automatic logic [CODE_W-1:0] fmt_code(input logic [CODE_W-1:0] code, input logic twosN);
        logic [CODE_W-1:0] res;
        res = code;
        if (!twosN)
        begin
            res[MSB_BIT] = ~code[MSB_BIT];
        end
        return res;
    endfunction

    // sample clock edges from the synchronised differential pair
    always_comb
    begin
        clkLvl = st_ff.syncB[SY_CLKT] & ~st_ff.syncB[SY_CLKC];
        clkRise = clkLvl & ~st_ff.clkPrev;
        clkFall = ~clkLvl & st_ff.clkPrev;
        if (st_ff.syncB[SY_HALVE])
        begin
            sampleEvt = clkRise;
            fwdRiseEvt = clkFall;
        end
        else
        begin
            sampleEvt = clkRise & ~st_ff.divPhase;
            fwdRiseEvt = clkRise & st_ff.divPhase;
        end
    end

    // converter pipeline delay
    apso_delay_line u_line (
        .ref_clk(ref_clk),
        .rst(rst),
        .advance(sampleEvt),
        .din({coreOver, coreCode}),
        .dout(pipeOut)
    );

    // next state of the whole block
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.syncA = {ref_source_sel, twos_format_sel_n, clock_halve_sel_n,
                        cal_reset_n, sample_clock_in_comp, sample_clock_in_true};
        nxt_st.syncB = st_ff.syncA;
        nxt_st.clkPrev = clkLvl;
        if (clkRise)
        begin
            nxt_st.divPhase = ~st_ff.divPhase;
        end
        nxt_st.refExt = st_ff.syncB[SY_REF];

        // calibration sequencing
        if (!st_ff.syncB[SY_RSTN])
        begin
            nxt_st.mode = APSO_HOLD;
            nxt_st.calCnt = CAL_LOAD;
        end
        else
        begin
            case (st_ff.mode)
                APSO_HOLD:
                begin
                    nxt_st.mode = APSO_CAL;
                    nxt_st.calCnt = CAL_LOAD;
                end
                APSO_CAL:
                begin
                    if (st_ff.calCnt == '0)
                    begin
                        nxt_st.mode = APSO_RUN;
                    end
                    else
                    begin
                        nxt_st.calCnt = st_ff.calCnt - 1'b1;
                    end
                end
                default:
                begin
                    nxt_st.mode = APSO_RUN;
                end
            endcase
        end

        // forwarded clock and sample word
        if (st_ff.mode == APSO_HOLD)
        begin
            nxt_st.fwdTrue = 1'b0;
            nxt_st.overTrue = 1'b1;
        end
        else if (sampleEvt)
        begin
            nxt_st.fwdTrue = 1'b0;
            nxt_st.dataTrue = fmt_code(pipeOut[CODE_W-1:0], st_ff.syncB[SY_TWOS]);
            nxt_st.overTrue = (st_ff.mode != APSO_RUN) | pipeOut[OVR_BIT];
        end
        else if (fwdRiseEvt)
        begin
            nxt_st.fwdTrue = 1'b1;
        end
        if (nxt_st.mode == APSO_HOLD)
        begin
            nxt_st.overTrue = 1'b1;
        end
        nxt_st.dataComp = ~nxt_st.dataTrue;
        nxt_st.fwdComp = ~nxt_st.fwdTrue;
        nxt_st.overComp = ~nxt_st.overTrue;

        // register port: writes, reads, read-clear status
        nxt_st.rdData = '0;
        if (regWr)
        begin
            if (regAddr == REG_MASK)
            begin
                nxt_st.mask = regWrData[EVT_W-1:0];
            end
        end
        if (regRd)
        begin
            if (regAddr == REG_STATUS)
            begin
                nxt_st.rdData = DATA_W'(st_ff.status);
                nxt_st.status = '0;
            end
            else if (regAddr == REG_MASK)
            begin
                nxt_st.rdData = DATA_W'(st_ff.mask);
            end
            else if (regAddr == REG_STATE)
            begin
                nxt_st.rdData[ST_RUN] = st_ff.mode == APSO_RUN;
                nxt_st.rdData[ST_CAL] = st_ff.mode == APSO_CAL;
                nxt_st.rdData[ST_HOLD] = st_ff.mode == APSO_HOLD;
                nxt_st.rdData[ST_HALVE] = st_ff.syncB[SY_HALVE];
                nxt_st.rdData[ST_TWOS] = st_ff.syncB[SY_TWOS];
                nxt_st.rdData[ST_REF] = st_ff.syncB[SY_REF];
            end
        end
        // events set after the clear so a coincident event survives
        if (st_ff.mode == APSO_CAL && nxt_st.mode == APSO_RUN)
        begin
            nxt_st.status[EV_CALDONE] = 1'b1;
        end
        if (sampleEvt && st_ff.mode == APSO_RUN && pipeOut[OVR_BIT])
        begin
            nxt_st.status[EV_OVR] = 1'b1;
        end
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);
    end

    // register the state
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_ff <= ST_RESET;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flip-flops
    assign regRdData = st_ff.rdData;
    assign irq = st_ff.irq;
    assign sample_bits_true = st_ff.dataTrue;
    assign sample_bits_comp = st_ff.dataComp;
    assign fwd_clock_true = st_ff.fwdTrue;
    assign fwd_clock_comp = st_ff.fwdComp;
    assign overrange_flag_true = st_ff.overTrue;
    assign overrange_flag_comp = st_ff.overComp;
    assign ref_source_ext = st_ff.refExt;

    // checks on the output behaviour
    // halved: the skipped rise lifts the forwarded clock instead of sampling
    halve_skip_a: assert property (@(posedge ref_clk) disable iff (rst)
        clkRise && !st_ff.syncB[SY_HALVE] && st_ff.divPhase && st_ff.mode != APSO_HOLD |=> fwd_clock_true)
        else $error("halved clock took a sample on odd edge");

    // undivided: every rise brings the forwarded clock low and, outside hold, starts a new word
    full_rate_a: assert property (@(posedge ref_clk) disable iff (rst)
        clkRise && st_ff.syncB[SY_HALVE] |=> !fwd_clock_true)
        else $error("undivided clock missed a sample");

    twos_fmt_a: assert property (@(posedge ref_clk) disable iff (rst)
        sampleEvt && st_ff.mode != APSO_HOLD |=>
        sample_bits_true[MSB_BIT] == ($past(pipeOut[MSB_BIT]) ^ !$past(st_ff.syncB[SY_TWOS])))
        else $error("output number format wrong");

    hold_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
        !st_ff.syncB[SY_RSTN] |=> st_ff.mode == APSO_HOLD)
        else $error("low reset input did not hold the device");

    ref_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 ref_source_ext == $past(st_ff.syncB[SY_REF]))
        else $error("reference select not followed");

    data_pair_a: assert property (@(posedge ref_clk) disable iff (rst)
        sample_bits_comp == ~sample_bits_true && overrange_flag_comp == !overrange_flag_true)
        else $error("differential data pair not complementary");

    fwd_pair_a: assert property (@(posedge ref_clk) disable iff (rst)
        fwd_clock_comp == !fwd_clock_true)
        else $error("forwarded clock pair not complementary");

    fwd_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
        fwdRiseEvt && st_ff.mode != APSO_HOLD && !sampleEvt |=> fwd_clock_true)
        else $error("forwarded clock did not rise");

    run_over_a: assert property (@(posedge ref_clk) disable iff (rst)
        sampleEvt && st_ff.mode == APSO_RUN && st_ff.syncB[SY_RSTN] |=>
        overrange_flag_true == $past(pipeOut[OVR_BIT]))
        else $error("delayed over-range not presented");

    over_forced_a: assert property (@(posedge ref_clk) disable iff (rst)
        st_ff.mode != APSO_RUN |-> overrange_flag_true)
        else $error("over-range not forced during calibration");

    fwd_low_a: assert property (@(posedge ref_clk) disable iff (rst)
        st_ff.mode == APSO_HOLD |=> !fwd_clock_true)
        else $error("forwarded clock toggled in reset");

    same_word_a: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(sample_bits_true) |-> $past(sampleEvt) && !fwd_clock_true)
        else $error("data changed outside a sample event");

    cal_done_c: cover property (@(posedge ref_clk) disable iff (rst)
        st_ff.mode == APSO_CAL ##1 st_ff.mode == APSO_RUN);
    recal_c: cover property (@(posedge ref_clk) disable iff (rst)
        st_ff.mode == APSO_RUN ##1 st_ff.mode == APSO_HOLD ##[1:20] st_ff.mode == APSO_CAL);
    irq_c: cover property (@(posedge ref_clk) disable iff (rst) $rose(irq));
    halved_c: cover property (@(posedge ref_clk) disable iff (rst)
        sampleEvt && !st_ff.syncB[SY_HALVE]);

endmodule
`default_nettype wire
